// ===== core/stc_pkg.sv
// constants for the sixteen bit timer counter block
package stc_pkg;

  // ------------------------------------------------------------
  // register offsets on the register port
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W         = 3;
  localparam logic [2:0]  OFS_COUNT_LOW  = 3'h0;
  localparam logic [2:0]  OFS_COUNT_HIGH = 3'h1;
  localparam logic [2:0]  OFS_CONTROL    = 3'h2;
  localparam logic [2:0]  OFS_FLAG       = 3'h3;
  localparam logic [2:0]  OFS_ENABLE     = 3'h4;

  // ------------------------------------------------------------
  // timer control fields
  // ------------------------------------------------------------
  localparam int unsigned CTL_RUN_BIT    = 0;
  localparam int unsigned CTL_SRC_BIT    = 1;
  localparam int unsigned CTL_NOSYNC_BIT = 2;
  localparam int unsigned CTL_OSCEN_BIT  = 3;
  localparam int unsigned CTL_PS_LSB     = 4;
  localparam int unsigned CTL_PS_MSB     = 5;
  localparam int unsigned CTL_WIDE_BIT   = 7;
  localparam logic [7:0]  CTL_WMASK      = 8'hBF;
  localparam logic [7:0]  CTL_RESET      = 8'h00;

  // ------------------------------------------------------------
  // flag and enable fields
  // ------------------------------------------------------------
  localparam int unsigned OVF_FLAG_BIT   = 0;
  localparam int unsigned OVF_IE_BIT     = 0;

  // ------------------------------------------------------------
  // counter values and compare mode
  // ------------------------------------------------------------
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [3:0]  CMP_MODE_SEV   = 4'hB;

  // ------------------------------------------------------------
  // prescale select codes and terminal counts
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    STC_PS_DIV1 = 2'b00,
    STC_PS_DIV2 = 2'b01,
    STC_PS_DIV4 = 2'b10,
    STC_PS_DIV8 = 2'b11
  } stc_ps_t;

  localparam logic [2:0]  PS_LAST_DIV1   = 3'h0;
  localparam logic [2:0]  PS_LAST_DIV2   = 3'h1;
  localparam logic [2:0]  PS_LAST_DIV4   = 3'h3;
  localparam logic [2:0]  PS_LAST_DIV8   = 3'h7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned OSC_MAX_HZ     = 200_000;
  // fewest core clocks in one half period of the fastest rated crystal
  localparam int unsigned OSC_HALF_CYC   = CLK_HZ / (2 * OSC_MAX_HZ);
  localparam int unsigned SYNC_STAGES    = 2;

endpackage

// ===== core/stc_edge_sync.sv
// two flop synchroniser with rising edge pulse
module stc_edge_sync
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // asynchronous pin level
  input  wire logic pin_in,
  // synchronised outputs
  output logic      level_out,
  output logic      rise_out
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // ------------------------------------------------------------
  // stage one feeds stage two only
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~last_r;

endmodule

// ===== core/stc_timer.sv
// sixteen bit timer counter with wide access buffer and compare reset
// Function
// - crystal amplifier runs only when enabled
// - crystal keeps running through sleep
// - count wraps FFFF to 0000, sets flag
// - interrupt request gated by enable bit
// - compare mode 1011 resets timer, no flag
// - trigger reset skipped in unsynchronised counter mode
// - software write beats trigger reset
// - compare pair acts as period
// - wide mode low byte read latches high into buffer
// - wide high write goes to buffer only
// - wide mode high address is the buffer
// - low byte write clears prescaler
// - source select picks instruction or external
// - prescale field divides by 1,2,4,8
// - run bit stops counting; compare reset still clears count
//
// The register addresses and the strobed register port were decided locally.
module stc_timer
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // instruction cycle enable from the core
  input  wire logic              instr_tick,
  // external clock and crystal pins
  input  wire logic              ext_clk_pin,
  input  wire logic              crystal_in_pin,
  output logic                   crystal_out_pin,
  output logic                   crystal_out_oe,
  // compare unit
  input  wire logic [3:0]        compare_mode_field,
  input  wire logic [15:0]       compare_value_pair,
  input  wire logic              adc_enable,
  output logic                   special_event,
  output logic                   adc_start,
  // interrupt request
  output logic                   overflow_irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] count_r;
  logic [7:0]  count_high_buffer_r;
  logic [7:0]  timer_control_r;
  logic        overflow_flag_r;
  logic        overflow_int_enable_r;
  logic [2:0]  psc_r;
  logic [7:0]  rdata_r;
  logic        sev_r;
  logic        adc_r;

  // control fields
  logic        timer_run_bit;
  logic        clock_source_select;
  logic        ext_sync_disable;
  logic        osc_enable_bit;
  logic        wide_access_enable;
  stc_ps_t     input_prescale_select;

  assign timer_run_bit         = timer_control_r[CTL_RUN_BIT];
  assign clock_source_select   = timer_control_r[CTL_SRC_BIT];
  assign ext_sync_disable      = timer_control_r[CTL_NOSYNC_BIT];
  assign osc_enable_bit        = timer_control_r[CTL_OSCEN_BIT];
  assign wide_access_enable    = timer_control_r[CTL_WIDE_BIT];
  assign input_prescale_select = stc_ps_t'(timer_control_r[CTL_PS_MSB:CTL_PS_LSB]);

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_low;
  logic wr_high;
  logic wr_ctl;
  logic wr_flag;
  logic wr_ie;
  logic rd_low;

  assign wr_low  = reg_wr & hit(reg_addr, OFS_COUNT_LOW);
  assign wr_high = reg_wr & hit(reg_addr, OFS_COUNT_HIGH);
  assign wr_ctl  = reg_wr & hit(reg_addr, OFS_CONTROL);
  assign wr_flag = reg_wr & hit(reg_addr, OFS_FLAG);
  assign wr_ie   = reg_wr & hit(reg_addr, OFS_ENABLE);
  assign rd_low  = reg_rd & hit(reg_addr, OFS_COUNT_LOW);

  // any software write that lands in the live count
  logic count_wr;
  assign count_wr = wr_low | (wr_high & ~wide_access_enable);

  // ------------------------------------------------------------
  // crystal oscillator amplifier
  // ------------------------------------------------------------
  // inverter drives only while enabled; no sleep input gates it
  assign crystal_out_pin = osc_enable_bit & ~crystal_in_pin;
  assign crystal_out_oe  = osc_enable_bit;

  // ------------------------------------------------------------
  // external edge synchronisers
  // ------------------------------------------------------------
  logic [1:0] pin_vec;
  logic [1:0] pin_rise;

  assign pin_vec = {crystal_in_pin, ext_clk_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      stc_edge_sync u_sync (
        .core_clk  (core_clk),
        .srst      (srst),
        .pin_in    (pin_vec[gi]),
        .level_out (),
        .rise_out  (pin_rise[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // count source and prescaler
  // ------------------------------------------------------------
  logic src_event;
  logic ext_event;
  logic psc_last;
  logic count_tick;

  // crystal replaces the external clock input while enabled
  assign ext_event = osc_enable_bit ? pin_rise[1] : pin_rise[0];
  assign src_event = clock_source_select ? ext_event : instr_tick;

  function automatic logic [2:0] ps_last(input stc_ps_t sel);
    unique case (sel)
      STC_PS_DIV1: ps_last = PS_LAST_DIV1;
      STC_PS_DIV2: ps_last = PS_LAST_DIV2;
      STC_PS_DIV4: ps_last = PS_LAST_DIV4;
      STC_PS_DIV8: ps_last = PS_LAST_DIV8;
    endcase
  endfunction

  assign psc_last   = (psc_r >= ps_last(input_prescale_select));
  assign count_tick = timer_run_bit & src_event & psc_last;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      psc_r <= 3'h0;
    end else if (wr_low) begin
      psc_r <= 3'h0;
    end else if (timer_run_bit && src_event) begin
      psc_r <= psc_last ? 3'h0 : psc_r + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // compare special event
  // ------------------------------------------------------------
  logic async_mode;
  logic sev_hit;
  logic overflow_hit;

  assign async_mode   = clock_source_select & ext_sync_disable;
  assign sev_hit      = (compare_mode_field == CMP_MODE_SEV)
                      && (count_r == compare_value_pair)
                      && !async_mode;
  assign overflow_hit = count_tick && (count_r == COUNT_MAX);

  // ------------------------------------------------------------
  // live count
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r <= COUNT_ZERO;
    end else if (wr_low && wide_access_enable) begin
      count_r <= {count_high_buffer_r, reg_wdata};
    end else if (wr_low) begin
      count_r[7:0] <= reg_wdata;
    end else if (wr_high && !wide_access_enable) begin
      count_r[15:8] <= reg_wdata;
    end else if (sev_hit) begin
      count_r <= COUNT_ZERO;
    end else if (count_tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // high byte buffer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_high_buffer_r <= BYTE_ZERO;
    end else if (wr_high && wide_access_enable) begin
      count_high_buffer_r <= reg_wdata;
    end else if (rd_low && wide_access_enable) begin
      count_high_buffer_r <= count_r[15:8];
    end
  end

  // ------------------------------------------------------------
  // control, flag and enable registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_control_r <= CTL_RESET;
    end else if (wr_ctl) begin
      timer_control_r <= reg_wdata & CTL_WMASK;
    end
  end

  // a wrap in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_flag_r <= 1'b0;
    end else if (overflow_hit && !count_wr && !sev_hit) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_flag) begin
      overflow_flag_r <= reg_wdata[OVF_FLAG_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_int_enable_r <= 1'b0;
    end else if (wr_ie) begin
      overflow_int_enable_r <= reg_wdata[OVF_IE_BIT];
    end
  end

  assign overflow_irq = overflow_flag_r & overflow_int_enable_r;

  // ------------------------------------------------------------
  // special event and converter start pulses
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sev_r <= 1'b0;
      adc_r <= 1'b0;
    end else begin
      sev_r <= sev_hit && !count_wr;
      adc_r <= sev_hit && !count_wr && adc_enable;
    end
  end

  assign special_event = sev_r;
  assign adc_start     = adc_r;

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= BYTE_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_COUNT_LOW:  rdata_r <= count_r[7:0];
        OFS_COUNT_HIGH: rdata_r <= wide_access_enable ? count_high_buffer_r
                                                      : count_r[15:8];
        OFS_CONTROL:    rdata_r <= timer_control_r;
        OFS_FLAG:       rdata_r <= {7'h00, overflow_flag_r};
        OFS_ENABLE:     rdata_r <= {7'h00, overflow_int_enable_r};
        default:        rdata_r <= BYTE_ZERO;
      endcase
    end else begin
      rdata_r <= BYTE_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_wide_high_write;
    wr_high && wide_access_enable && !wr_ctl;
  endsequence

  sequence s_wide_low_write;
    wr_low && wide_access_enable;
  endsequence

  a_osc_gated: assert property (!osc_enable_bit |-> !crystal_out_oe && !crystal_out_pin)
    else $error("crystal amplifier active while disabled");

  a_wrap_flag: assert property (overflow_hit && !count_wr && !sev_hit
                                |=> count_r == COUNT_ZERO && overflow_flag_r)
    else $error("overflow did not wrap to zero and set flag");

  a_irq_gate: assert property ($rose(overflow_flag_r) && !overflow_int_enable_r
                               |-> !overflow_irq)
    else $error("interrupt raised while disabled");

  a_trig_reset: assert property (sev_hit && !count_wr && !wr_flag
                                 |=> count_r == COUNT_ZERO && special_event
                                     && !$rose(overflow_flag_r))
    else $error("special event did not clear count cleanly");

  a_write_wins: assert property (wr_low && !wide_access_enable && sev_hit
                                 |=> count_r[7:0] == $past(reg_wdata) && !special_event)
    else $error("trigger reset beat a software write");

  a_wide_write: assert property (s_wide_high_write ##1 s_wide_low_write
                                 |=> count_r == {$past(count_high_buffer_r), $past(reg_wdata)})
    else $error("wide write did not load both bytes");

  a_wide_read: assert property (rd_low && wide_access_enable && !wr_high
                                |=> count_high_buffer_r == $past(count_r[15:8]))
    else $error("low byte read did not latch high byte");

  a_psc_clear: assert property (wr_low |=> psc_r == 3'h0)
    else $error("prescaler not cleared by low byte write");

  a_run_hold: assert property (!timer_run_bit && !reg_wr && !sev_hit
                               |=> count_r == $past(count_r))
    else $error("count moved while stopped");

  a_rd_latency: assert property (reg_rd && reg_addr == OFS_CONTROL
                                 |=> reg_rdata == $past(timer_control_r))
    else $error("read data not returned next cycle");

  a_wide_hread: assert property (reg_rd && reg_addr == OFS_COUNT_HIGH && wide_access_enable
                                 |=> reg_rdata == $past(count_high_buffer_r))
    else $error("wide high read did not return the buffer");

  a_async_nosev: assert property (async_mode && compare_mode_field == CMP_MODE_SEV
                                  |=> !special_event && !adc_start)
    else $error("trigger reset fired in unsynchronised counter mode");

  a_adc_pair: assert property (adc_start |-> special_event)
    else $error("converter start without special event");

endmodule

// ===== tb/stc_clk_src.sv
// external clock and crystal source model for the timer bench
module stc_clk_src
  import stc_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // burst request
  input  wire logic       start,
  input  wire logic       use_xtal,
  input  wire logic [3:0] n_pulses,
  // pins and status
  output logic            ext_clk_pin,
  output logic            crystal_in_pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lvl;
  int   half;

  // both lines stand low outside a burst
  assign ext_clk_pin    = lvl & ~use_xtal;
  assign crystal_in_pin = lvl & use_xtal;

  initial begin
    lvl  = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (start) begin
        busy <= 1'b1;
        // crystal never faster than its rated rate
        half = use_xtal ? int'(OSC_HALF_CYC) : 3;
        repeat (n_pulses) begin
          lvl <= 1'b1;
          repeat (half) @(posedge core_clk);
          lvl <= 1'b0;
          repeat (half) @(posedge core_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/tb_stc_timer.sv
// self-checking bench for the sixteen bit timer counter
module tb_stc_timer
  import stc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_rdata;
  logic              instr_tick = 1'b0;
  logic              ext_clk_pin;
  logic              crystal_in_pin;
  logic              crystal_out_pin;
  logic              crystal_out_oe;
  logic [3:0]        compare_mode_field = 4'h0;
  logic [15:0]       compare_value_pair = 16'h0000;
  logic              adc_enable = 1'b0;
  logic              special_event;
  logic              adc_start;
  logic              overflow_irq;
  logic              start = 1'b0;
  logic              use_xtal = 1'b0;
  logic [3:0]        n_pulses = 4'h0;
  logic              busy;
  int                err_count = 0;
  int                compares = 0;
  int                sev_cnt = 0;
  int                adc_cnt = 0;
  int                s0;
  int                a0;

  always #12.5 core_clk = ~core_clk;

  stc_timer stc_timer_inst (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_tick(instr_tick),
    .ext_clk_pin(ext_clk_pin), .crystal_in_pin(crystal_in_pin),
    .crystal_out_pin(crystal_out_pin), .crystal_out_oe(crystal_out_oe),
    .compare_mode_field(compare_mode_field), .compare_value_pair(compare_value_pair),
    .adc_enable(adc_enable), .special_event(special_event), .adc_start(adc_start),
    .overflow_irq(overflow_irq)
  );

  stc_clk_src stc_clk_src_inst (
    .core_clk(core_clk), .start(start), .use_xtal(use_xtal), .n_pulses(n_pulses),
    .ext_clk_pin(ext_clk_pin), .crystal_in_pin(crystal_in_pin), .busy(busy)
  );

  always @(posedge core_clk) begin
    if (special_event === 1'b1) sev_cnt <= sev_cnt + 1;
    if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, e});
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      instr_tick <= 1'b1;
      @(posedge core_clk);
      instr_tick <= 1'b0;
    end
  endtask

  task automatic burst(input logic x, input logic [3:0] n);
    int i;
    @(posedge core_clk);
    use_xtal <= x;
    n_pulses <= n;
    start    <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 2000 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (busy !== 1'b0) begin
      err_count++;
      print_verdict();
    end
    repeat (4) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(OFS_CONTROL, CTL_RESET);
    rd_chk(OFS_COUNT_LOW, 8'h00);
    wr(OFS_CONTROL, 8'hFF);
    rd_chk(OFS_CONTROL, CTL_WMASK);
    wr(3'h6, 8'h5A);
    rd_chk(3'h6, 8'h00);
    for (int ps = 0; ps < 4; ps++) begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_CONTROL, {2'b00, 2'(ps), 4'h1});
      ticks(8);
      wr(OFS_CONTROL, 8'h00);
      rd_chk(OFS_COUNT_LOW, 8'(8 >> ps));
    end
    wr(OFS_CONTROL, 8'h11);
    wr(OFS_COUNT_LOW, 8'h00);
    ticks(1);
    wr(OFS_COUNT_HIGH, 8'h00);
    ticks(1);
    wr(OFS_CONTROL, 8'h10);
    ticks(2);
    rd_chk(OFS_COUNT_LOW, 8'h01);
    wr(OFS_COUNT_HIGH, 8'hFF);
    wr(OFS_COUNT_LOW, 8'hFF);
    wr(OFS_CONTROL, 8'h01);
    ticks(1);
    wr(OFS_CONTROL, 8'h00);
    rd_chk(OFS_COUNT_HIGH, 8'h00);
    rd_chk(OFS_FLAG, 8'h01);
    check({15'h0, overflow_irq}, 16'h0000);
    wr(OFS_ENABLE, 8'h01);
    check({15'h0, overflow_irq}, 16'h0001);
    wr(OFS_ENABLE, 8'h00);
    check({15'h0, overflow_irq}, 16'h0000);
    wr(OFS_FLAG, 8'h00);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_HIGH, 8'h12);
    rd_chk(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_COUNT_LOW, 8'h34);
    wr(OFS_CONTROL, 8'h00);
    rd_chk(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_HIGH, 8'h56);
    rd_chk(OFS_COUNT_LOW, 8'h34);
    rd_chk(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT_HIGH, 8'h00);
    wr(OFS_COUNT_LOW, 8'h00);
    @(posedge core_clk);
    compare_value_pair <= 16'h0005;
    compare_mode_field <= CMP_MODE_SEV;
    adc_enable         <= 1'b1;
    s0 = sev_cnt;
    a0 = adc_cnt;
    wr(OFS_CONTROL, 8'h01);
    ticks(7);
    wr(OFS_CONTROL, 8'h00);
    rd_chk(OFS_COUNT_LOW, 8'h02);
    check(16'(sev_cnt - s0), 16'h0001);
    check(16'(adc_cnt - a0), 16'h0001);
    rd_chk(OFS_FLAG, 8'h00);
    @(posedge core_clk);
    compare_value_pair <= 16'h0000;
    wr(OFS_COUNT_LOW, 8'h00);
    wr(OFS_COUNT_LOW, 8'h07);
    rd_chk(OFS_COUNT_LOW, 8'h07);
    @(posedge core_clk);
    adc_enable <= 1'b0;
    wr(OFS_CONTROL, 8'h06);
    @(posedge core_clk);
    compare_value_pair <= 16'h0007;
    repeat (4) @(posedge core_clk);
    rd_chk(OFS_COUNT_LOW, 8'h07);
    s0 = sev_cnt;
    a0 = adc_cnt;
    wr(OFS_CONTROL, 8'h02);
    rd_chk(OFS_COUNT_LOW, 8'h00);
    check(16'(sev_cnt - s0), 16'h0001);
    check(16'(adc_cnt - a0), 16'h0000);
    @(posedge core_clk);
    compare_mode_field <= 4'h0;
    wr(OFS_CONTROL, 8'h03);
    burst(1'b0, 4'h5);
    ticks(3);
    rd_chk(OFS_COUNT_LOW, 8'h05);
    wr(OFS_CONTROL, 8'h0B);
    check({15'h0, crystal_out_oe}, 16'h0001);
    check({15'h0, crystal_out_pin}, 16'h0001);
    // software start-up delay before trusting the crystal
    repeat (20) @(posedge core_clk);
    burst(1'b1, 4'h3);
    wr(OFS_CONTROL, 8'h00);
    rd_chk(OFS_COUNT_LOW, 8'h08);
    check({15'h0, crystal_out_oe}, 16'h0000);
    print_verdict();
  end
endmodule
